/* src/febs_consts.vh */
// Constants for the flash erase-select and boot-entry block
`ifndef FEBS_CONSTS_VH
`define FEBS_CONSTS_VH

// ---------------------------------------------------------------
// Register addresses (lower 16 bits) and field positions
// ---------------------------------------------------------------
`define FEBS_ADDR_EBR_HI   16'hFF82
`define FEBS_ADDR_EBR_LO   16'hFF83
`define FEBS_ADDR_SERIAL_TIMER_CONTROL     16'hFFC3
`define FEBS_SERIAL_TIMER_CONTROL_WIN_BIT  3
`define FEBS_REG_RESET     8'h00
`define FEBS_HI_MASK       8'h03
`define FEBS_NORM_LO_MASK  8'h7F
`define FEBS_NORM_HI_MASK  8'h00

// ---------------------------------------------------------------
// Erase block start addresses (17-bit flash address)
// ---------------------------------------------------------------
`define FEBS_B1_START      17'h00400
`define FEBS_B2_START      17'h00800
`define FEBS_B3_START      17'h00C00
`define FEBS_B4_START      17'h01000
`define FEBS_B5_START      17'h08000
`define FEBS_B6_START      17'h0C000
`define FEBS_B7_START      17'h0E000
`define FEBS_B8_START      17'h10000
`define FEBS_B9_START      17'h18000

// ---------------------------------------------------------------
// Boot serial protocol
// ---------------------------------------------------------------
`define FEBS_WAIT_STATES   7'd100
`define FEBS_LOW_BITS      4'h9
`define FEBS_SYNC_BYTE     8'h00
`define FEBS_ACK_BYTE      8'h55
`define FEBS_PROG_BASE     16'hE080
`define FEBS_PROG_LEN      12'hF80
`define FEBS_STOP_IDX      4'h9
`define FEBS_TX_FRAME      4'hA

`endif

/* src/febs_buf2.v */
// Two-entry valid/ready buffer with head held in flip-flops
`timescale 1ns/100ps

module febs_buf2 #(
    parameter WIDTH = 24
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    // -----------------------------------------------------------
    // Storage: slot 0 is always the head
    // -----------------------------------------------------------
    reg [WIDTH-1:0] mem_q [0:1];  // Entries
    reg [1:0]       vld_q;        // Per-entry valid
    wire            pop;          // Head taken
    wire            push;         // New word accepted

    assign in_ready  = ~vld_q[1];
    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];
    assign pop       = vld_q[0] & out_ready;
    assign push      = in_valid & ~vld_q[1];

    // Shift on pop, fill first free slot on push
    always @(posedge clk) begin
        if (!reset_n) begin
            vld_q    <= 2'h0;
            mem_q[0] <= {WIDTH{1'b0}};
            mem_q[1] <= {WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b01: begin
                    // Drain one
                    mem_q[0] <= mem_q[1];
                    vld_q    <= {1'b0, vld_q[1]};
                end
                2'b10: begin
                    // Fill one
                    if (vld_q[0]) begin
                        mem_q[1] <= in_data;
                        vld_q[1] <= 1'b1;
                    end else begin
                        mem_q[0] <= in_data;
                        vld_q[0] <= 1'b1;
                    end
                end
                2'b11: begin
                    // Pass through while draining
                    if (vld_q[1]) begin
                        mem_q[0] <= mem_q[1];
                        mem_q[1] <= in_data;
                    end else begin
                        mem_q[0] <= in_data;
                    end
                end
                default: begin
                    // Hold
                    vld_q <= vld_q;
                end
            endcase
        end
    end

endmodule

/* src/febs_top.v */
// Flash erase-select registers, window select and boot-mode entry
`timescale 1ns/100ps
`include "febs_consts.vh"

module febs_top #(
    parameter BIT_W = 16
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        standby_any,
    input  wire        hw_standby,
    input  wire        flash_enabled,
    input  wire        software_write_enable,
    input  wire        mode_pin_1,
    input  wire        mode_pin_0,
    input  wire        boot_strap_pin_2,
    input  wire        boot_strap_pin_1,
    input  wire        boot_strap_pin_0,
    input  wire [15:0] cpu_addr,
    input  wire        cpu_wr_en,
    input  wire        cpu_rd_en,
    input  wire [7:0]  cpu_wdata,
    output reg  [7:0]  cpu_rdata,
    output reg         periph_area_sel,
    input  wire [16:0] erase_addr,
    output reg  [9:0]  erase_block_sel,
    output reg         erase_addr_allowed,
    output reg  [7:0]  serial_timer_control,
    output reg         boot_mode,
    output reg         user_mode_advanced,
    output reg         user_mode_normal,
    output reg         strap_pins_free,
    input  wire        boot_serial_rx,
    output reg         boot_serial_tx,
    output reg         boot_overrun,
    output wire        ram_wr_valid,
    input  wire        ram_wr_ready,
    output wire [15:0] ram_wr_addr,
    output wire [7:0]  ram_wr_data,
    output reg         boot_branch,
    output reg  [BIT_W-1:0] bit_period
);

    // -----------------------------------------------------------
    // State codes of the boot sequencer
    // -----------------------------------------------------------
    localparam S_OFF  = 3'h0;  // Not in boot mode
    localparam S_WAIT = 3'h1;  // Settling after reset
    localparam S_IDLE = 3'h2;  // Wait for first low
    localparam S_MEAS = 3'h3;  // Timing the low period
    localparam S_SEND = 3'h4;  // Sending end-of-adjust byte
    localparam S_ACK  = 3'h5;  // Waiting for answer byte
    localparam S_LOAD = 3'h6;  // Receiving the program
    localparam S_RUN  = 3'h7;  // Program running

    // -----------------------------------------------------------
    // Registers and nets
    // -----------------------------------------------------------
    reg  [1:0]       hi_q;       // Blocks 9..8 select
    reg  [7:0]       lo_q;       // Blocks 7..0 select
    reg  [2:0]       st_q;       // Sequencer state
    reg  [6:0]       wait_q;     // Settle counter
    reg  [3:0]       pre_q;      // Divide-by-nine prescaler
    reg  [BIT_W-1:0] meas_q;     // Measured bit time
    reg              rx_busy_q;  // Receiver in a frame
    reg  [BIT_W-1:0] rx_cnt_q;   // Receiver bit timer
    reg  [3:0]       rx_idx_q;   // Receiver bit index
    reg  [7:0]       rx_sh_q;    // Receiver shift register
    reg              rx_vld_q;   // Byte received pulse
    reg              tx_busy_q;  // Transmitter in a frame
    reg  [BIT_W-1:0] tx_cnt_q;   // Transmitter bit timer
    reg  [3:0]       tx_idx_q;   // Bits left to send
    reg  [9:0]       tx_sh_q;    // Transmit frame shifter
    reg  [11:0]      ld_cnt_q;   // Program bytes stored
    reg  [3:0]       blk_idx;    // Block holding erase_addr
    wire [9:0]       sel_all = {hi_q, lo_q}; // Blocks 9..0 select
    wire             win;        // Flash window selected
    wire             normal;     // Normal CPU mode
    wire             ebr_hit;    // Shared flash address hit
    wire             wr_ok;      // Flash register write allowed
    wire             clr_sel;    // Force select registers clear
    wire [7:0]       lo_mask;    // Writable low bits
    wire [7:0]       hi_mask;    // Writable high bits
    wire             buf_ready;  // Buffer can take a byte
    wire             store;      // Program byte to buffer

    assign win     = serial_timer_control[`FEBS_SERIAL_TIMER_CONTROL_WIN_BIT];
    assign normal  = user_mode_normal;
    assign ebr_hit = (cpu_addr == `FEBS_ADDR_EBR_HI) |
                     (cpu_addr == `FEBS_ADDR_EBR_LO);
    assign wr_ok   = cpu_wr_en & win & flash_enabled;
    assign clr_sel = standby_any | ~software_write_enable;
    assign lo_mask = normal ? `FEBS_NORM_LO_MASK : 8'hFF;
    assign hi_mask = normal ? `FEBS_NORM_HI_MASK
                            : `FEBS_HI_MASK;
    assign store   = (st_q == S_LOAD) & rx_vld_q;

    // -----------------------------------------------------------
    // Mode pins: sampled while reset is held
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            boot_mode <= ~mode_pin_1 & ~mode_pin_0 &
                         boot_strap_pin_2 & boot_strap_pin_1 &
                         boot_strap_pin_0;
            user_mode_advanced <= mode_pin_1 & ~mode_pin_0;
            user_mode_normal   <= mode_pin_0;
        end
    end

    // -----------------------------------------------------------
    // Erase select registers
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n || clr_sel) begin
            hi_q <= 2'h0;
            lo_q <= `FEBS_REG_RESET;
        end else if (wr_ok) begin
            // Window clear leaves contents untouched
            if (cpu_addr == `FEBS_ADDR_EBR_HI)
                hi_q <= cpu_wdata[1:0] & hi_mask[1:0];
            if (cpu_addr == `FEBS_ADDR_EBR_LO)
                lo_q <= cpu_wdata & lo_mask;
        end else begin
            // Mode change cannot leave locked bits set
            hi_q <= hi_q & hi_mask[1:0];
            lo_q <= lo_q & lo_mask;
        end
    end

    // -----------------------------------------------------------
    // Serial/timer control register
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n || hw_standby) begin
            serial_timer_control <= `FEBS_REG_RESET;
        end else if (cpu_wr_en && cpu_addr == `FEBS_ADDR_SERIAL_TIMER_CONTROL) begin
            serial_timer_control <= cpu_wdata;
        end
    end

    // -----------------------------------------------------------
    // Read data and area routing
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            cpu_rdata       <= 8'h00;
            periph_area_sel <= 1'b0;
        end else begin
            periph_area_sel <= ebr_hit & ~win &
                               (cpu_rd_en | cpu_wr_en);
            if (!cpu_rd_en)
                cpu_rdata <= 8'h00;
            else if (cpu_addr == `FEBS_ADDR_SERIAL_TIMER_CONTROL)
                cpu_rdata <= serial_timer_control;
            else if (!ebr_hit || !win || !flash_enabled)
                cpu_rdata <= 8'h00;
            else if (cpu_addr == `FEBS_ADDR_EBR_HI)
                cpu_rdata <= {6'h00, hi_q};
            else
                cpu_rdata <= lo_q;
        end
    end

    // -----------------------------------------------------------
    // Block lookup for the address being erased
    // -----------------------------------------------------------
    always @* begin
        if (erase_addr >= `FEBS_B9_START)
            blk_idx = 4'h9;
        else if (erase_addr >= `FEBS_B8_START)
            blk_idx = 4'h8;
        else if (erase_addr >= `FEBS_B7_START)
            blk_idx = 4'h7;
        else if (erase_addr >= `FEBS_B6_START)
            blk_idx = 4'h6;
        else if (erase_addr >= `FEBS_B5_START)
            blk_idx = 4'h5;
        else if (erase_addr >= `FEBS_B4_START)
            blk_idx = 4'h4;
        else if (erase_addr >= `FEBS_B3_START)
            blk_idx = 4'h3;
        else if (erase_addr >= `FEBS_B2_START)
            blk_idx = 4'h2;
        else if (erase_addr >= `FEBS_B1_START)
            blk_idx = 4'h1;
        else
            blk_idx = 4'h0;
    end

    // Select and permission outputs, gated by flash enable
    always @(posedge clk) begin
        if (!reset_n) begin
            erase_block_sel    <= 10'h000;
            erase_addr_allowed <= 1'b0;
        end else begin
            erase_block_sel <= flash_enabled ? {hi_q, lo_q}
                                             : 10'h000;
            erase_addr_allowed <= flash_enabled &
                                  sel_all[blk_idx];
        end
    end

    // -----------------------------------------------------------
    // Boot sequencer: settle, measure, handshake, load
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            st_q            <= S_OFF;
            wait_q          <= 7'h00;
            pre_q           <= 4'h0;
            meas_q          <= {BIT_W{1'b0}};
            ld_cnt_q        <= 12'h000;
            boot_branch     <= 1'b0;
            strap_pins_free <= 1'b0;
        end else begin
            case (st_q)
                S_OFF: begin
                    // Leave idle unless strapped for boot
                    if (boot_mode) begin
                        st_q            <= S_WAIT;
                        strap_pins_free <= 1'b1;
                    end
                end
                S_WAIT: begin
                    // Settle time before low-period timing
                    wait_q <= wait_q + 7'h01;
                    if (wait_q == `FEBS_WAIT_STATES - 7'h01)
                        st_q <= S_IDLE;
                end
                S_IDLE: begin
                    // First low cycle counts, or the period comes short
                    pre_q  <= {3'h0, ~boot_serial_rx};
                    meas_q <= {BIT_W{1'b0}};
                    if (!boot_serial_rx)
                        st_q <= S_MEAS;
                end
                S_MEAS: begin
                    // Low period spans start plus eight zeros
                    if (boot_serial_rx) begin
                        if (meas_q == {BIT_W{1'b0}})
                            st_q <= S_IDLE;
                        else
                            st_q <= S_SEND;
                    end else if (pre_q == `FEBS_LOW_BITS - 4'h1) begin
                        pre_q <= 4'h0;
                        if (~&meas_q)
                            meas_q <= meas_q + 1'b1;
                    end else begin
                        pre_q <= pre_q + 4'h1;
                    end
                end
                S_SEND: begin
                    // Transmit launched below; wait until its stop bit starts
                    if (tx_busy_q && tx_idx_q == 4'h1 &&
                        tx_cnt_q == {BIT_W{1'b0}})
                        st_q <= S_ACK;
                end
                S_ACK: begin
                    // Stray sync bytes are dropped here
                    if (rx_vld_q && rx_sh_q == `FEBS_ACK_BYTE)
                        st_q <= S_LOAD;
                end
                S_LOAD: begin
                    // Count stored bytes up to the area size
                    if (store && buf_ready) begin
                        ld_cnt_q <= ld_cnt_q + 12'h001;
                        if (ld_cnt_q == `FEBS_PROG_LEN - 12'h001)
                            st_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    // Branch once the last byte left the buffer
                    boot_branch <= ~ram_wr_valid;
                end
                default: begin
                    st_q <= S_OFF;
                end
            endcase
        end
    end

    // Measured period published for the serial unit
    always @(posedge clk) begin
        if (!reset_n)
            bit_period <= {BIT_W{1'b0}};
        else if (st_q == S_SEND)
            bit_period <= meas_q;
    end

    // -----------------------------------------------------------
    // Receiver: 8 data bits, one stop, no parity
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q  <= {BIT_W{1'b0}};
            rx_idx_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
            rx_vld_q  <= 1'b0;
        end else begin
            rx_vld_q <= 1'b0;
            if (!rx_busy_q) begin
                // Start edge: sample at mid-bit
                if (!boot_serial_rx && st_q >= S_ACK &&
                    st_q != S_RUN) begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q  <= {1'b0, bit_period[BIT_W-1:1]};
                    rx_idx_q  <= 4'h0;
                end
            end else if (rx_cnt_q != {BIT_W{1'b0}}) begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end else begin
                rx_cnt_q <= bit_period - 1'b1;
                rx_idx_q <= rx_idx_q + 4'h1;
                if (rx_idx_q == 4'h0) begin
                    // False start is abandoned
                    if (boot_serial_rx)
                        rx_busy_q <= 1'b0;
                end else if (rx_idx_q == `FEBS_STOP_IDX) begin
                    rx_busy_q <= 1'b0;
                    rx_vld_q  <= boot_serial_rx;
                end else begin
                    rx_sh_q <= {boot_serial_rx, rx_sh_q[7:1]};
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Transmitter: one end-of-adjust byte
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            tx_busy_q      <= 1'b0;
            tx_cnt_q       <= {BIT_W{1'b0}};
            tx_idx_q       <= 4'h0;
            tx_sh_q        <= 10'h3FF;
            boot_serial_tx <= 1'b1;
        end else if (!tx_busy_q) begin
            boot_serial_tx <= 1'b1;
            if (st_q == S_SEND && bit_period != {BIT_W{1'b0}}) begin
                // Frame: start, data LSB first, stop
                tx_busy_q <= 1'b1;
                tx_sh_q   <= {1'b1, `FEBS_SYNC_BYTE, 1'b0};
                tx_idx_q  <= `FEBS_TX_FRAME;
                tx_cnt_q  <= {BIT_W{1'b0}};
            end
        end else if (tx_cnt_q != {BIT_W{1'b0}}) begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
        end else if (tx_idx_q == 4'h0) begin
            tx_busy_q      <= 1'b0;
            boot_serial_tx <= 1'b1;
        end else begin
            boot_serial_tx <= tx_sh_q[0];
            tx_sh_q        <= {1'b1, tx_sh_q[9:1]};
            tx_idx_q       <= tx_idx_q - 4'h1;
            tx_cnt_q       <= bit_period - 1'b1;
        end
    end

    // Byte arriving with the buffer full is flagged
    always @(posedge clk) begin
        if (!reset_n)
            boot_overrun <= 1'b0;
        else if (store && !buf_ready)
            boot_overrun <= 1'b1;
    end

    // -----------------------------------------------------------
    // Program bytes to RAM through the two-entry buffer
    // -----------------------------------------------------------
    febs_buf2 #(
        .WIDTH(24)
    ) u_buf (
        .clk      (clk),
        .reset_n  (reset_n),
        .in_valid (store),
        .in_ready (buf_ready),
        .in_data  ({`FEBS_PROG_BASE + {4'h0, ld_cnt_q},
                    rx_sh_q}),
        .out_valid(ram_wr_valid),
        .out_ready(ram_wr_ready),
        .out_data ({ram_wr_addr, ram_wr_data})
    );

endmodule

/* dv/febs_top_sva.sv */
// Port assertions for the erase-select and boot-entry block
`timescale 1ns/100ps
module febs_top_sva (
    input wire        clk,
    input wire        reset_n,
    input wire        standby_any,
    input wire        hw_standby,
    input wire        flash_enabled,
    input wire        software_write_enable,
    input wire [15:0] cpu_addr,
    input wire        cpu_wr_en,
    input wire        cpu_rd_en,
    input wire [7:0]  cpu_wdata,
    input wire [7:0]  cpu_rdata,
    input wire        periph_area_sel,
    input wire [9:0]  erase_block_sel,
    input wire [7:0]  serial_timer_control,
    input wire        user_mode_normal
);
    // Access lands in the shared register pair
    wire fa = (cpu_addr == 16'hFF82) || (cpu_addr == 16'hFF83);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_standby_sel_clear: assert property (
        standby_any |-> ##2 erase_block_sel == 10'h000)
        else $error("selects kept in standby");
    a_swe_sel_clear: assert property (
        !software_write_enable |-> ##2 erase_block_sel == 10'h000)
        else $error("selects kept without write enable");
    a_off_sel_zero: assert property (
        !flash_enabled [*3] |-> erase_block_sel == 10'h000)
        else $error("selects live while flash off");
    a_off_read_zero: assert property (
        cpu_rd_en && fa && !flash_enabled |=> cpu_rdata == 8'h00)
        else $error("nonzero read while flash off");
    a_window_route: assert property (
        (cpu_rd_en || cpu_wr_en) && fa
        |=> periph_area_sel == !$past(serial_timer_control[3]))
        else $error("shared area routed wrongly");
    a_ctrl_write: assert property (
        cpu_wr_en && cpu_addr == 16'hFFC3 && !hw_standby
        |=> serial_timer_control == $past(cpu_wdata))
        else $error("control byte write lost");
    a_ctrl_hw_clear: assert property (
        hw_standby |=> serial_timer_control == 8'h00)
        else $error("control byte kept in standby");
    a_normal_lock: assert property (
        user_mode_normal |-> erase_block_sel[9:7] == 3'b000)
        else $error("locked block selected");
endmodule
bind febs_top febs_top_sva febs_top_sva_inst (.*);

/* dv/febs_host.sv */
// Host model on the boot serial link
`timescale 1ns/100ps
module febs_host #(
    parameter BIT = 16
) (
    input  wire       clk,
    input  wire       go,
    input  wire       tx,
    output reg        rx,
    output reg  [7:0] got,
    output reg        got_ok
);
    reg        seen;
    reg [9:0]  f;
    integer    i, j, k;
    // Start, eight bits LSB first, one stop, no parity
    task send(input [7:0] b);
        for (k = 0; k < 10; k = k + 1) begin
            f = {1'b1, b, 1'b0};
            rx = f[k];
            repeat (BIT) @(negedge clk);
        end
    endtask
    // Zero bytes until answered, then 0x55 and two program bytes
    initial begin
        rx = 1'b1;
        seen = 1'b0;
        @(posedge go);
        while (!seen) send(8'h00);
        while (got_ok !== 1'b1) @(negedge clk);
        send(8'h55);
        for (i = 0; i < 2; i = i + 1) send(8'hA0 + i);
    end
    // Decode the device answer at mid bit
    initial begin
        got_ok = 1'b0;
        @(negedge tx);
        seen = 1'b1;
        repeat (BIT * 3 / 2) @(negedge clk);
        for (j = 0; j < 8; j = j + 1) begin
            got[j] = tx;
            repeat (BIT) @(negedge clk);
        end
        got_ok = tx;
    end
endmodule

/* dv/tb_febs_top.sv */
// Self-checking bench for the erase-select and boot-entry block
`timescale 1ns/100ps
module tb_febs_top;
    reg  clk = 1'b0, reset_n = 1'b0, standby_any = 1'b0, hw_standby = 1'b0;
    reg  flash_enabled = 1'b1, software_write_enable = 1'b1;
    reg  mode_pin_1 = 1'b0, mode_pin_0 = 1'b0, go = 1'b0, ram_wr_ready = 1'b0;
    reg  boot_strap_pin_2 = 1'b1, boot_strap_pin_1 = 1'b1;
    reg  boot_strap_pin_0 = 1'b1, cpu_wr_en = 1'b0, cpu_rd_en = 1'b0;
    reg  [15:0] cpu_addr = 16'h0000;
    reg  [7:0]  cpu_wdata = 8'h00;
    reg  [16:0] erase_addr = 17'h00000;
    wire [7:0]  cpu_rdata, serial_timer_control, ram_wr_data, got;
    wire [9:0]  erase_block_sel;
    wire [15:0] ram_wr_addr, bit_period;
    wire        periph_area_sel, erase_addr_allowed, boot_mode, boot_branch;
    wire        user_mode_advanced, user_mode_normal, strap_pins_free, got_ok;
    wire        boot_serial_tx, boot_serial_rx, boot_overrun, ram_wr_valid;
    integer     err_total = 0, comparisons = 0, i;
    reg  [7:0]  q;
    // Block start addresses, block 0 in the low slice
    wire [169:0] st = {17'h18000, 17'h10000, 17'h0E000, 17'h0C000,
        17'h08000, 17'h01000, 17'h00C00, 17'h00800, 17'h00400, 17'h00000};
    febs_top febs_top_inst (.*);
    febs_host febs_host_inst (.clk(clk), .go(go), .tx(boot_serial_tx),
        .rx(boot_serial_rx), .got(got), .got_ok(got_ok));
    always #5 clk = ~clk;
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // One-cycle strobe; read data taken in the following cycle
    task acc(input w, input [15:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {cpu_wr_en, cpu_rd_en, cpu_addr, cpu_wdata} = {w, !w, a, d};
            @(negedge clk);
            {cpu_wr_en, cpu_rd_en} = 2'b00;
            q = cpu_rdata;
        end
    endtask
    task rst(input m1, input m0);
        begin
            {reset_n, mode_pin_1, mode_pin_0} = {1'b0, m1, m0};
            repeat (8) @(negedge clk);
            reset_n = 1'b1;
        end
    endtask
    task t_boot;
        begin
            chk(boot_mode, 1);
            repeat (120) @(negedge clk);
            go = 1'b1;
            for (i = 0; i < 3000 && got_ok !== 1'b1; i = i + 1) @(negedge clk);
            chk(bit_period, 16);
            chk(got, 8'h00);
            chk(strap_pins_free, 1);
            repeat (600) @(negedge clk);
            chk({ram_wr_valid, ram_wr_data}, 16'h01A0);
            chk(ram_wr_addr, 16'hE080);
            ram_wr_ready = 1'b1;
            @(negedge clk);
            chk({ram_wr_addr[7:0], ram_wr_data}, 16'h81A1);
            @(negedge clk);
            ram_wr_ready = 1'b0;
            chk({ram_wr_valid, boot_overrun, boot_branch}, 0);
        end
    endtask
    task t_map;
        begin
            chk({user_mode_advanced, boot_mode}, 2'b10);
            acc(1, 16'hFFC3, 8'h08);
            acc(0, 16'hFF83, 8'h00);
            chk(q, 8'h00);
            for (i = 0; i < 10; i = i + 1) begin
                acc(1, (i < 8) ? 16'hFF82 : 16'hFF83, 8'h00);
                acc(1, (i < 8) ? 16'hFF83 : 16'hFF82, 8'h01 << (i % 8));
                @(negedge clk);
                chk(erase_block_sel, 10'h001 << i);
                erase_addr = st[17*i +: 17];
                @(negedge clk);
                chk(erase_addr_allowed, 1);
                erase_addr = st[17*((i+1)%10) +: 17] - 17'h00001;
                @(negedge clk);
                chk(erase_addr_allowed, 1);
                erase_addr = st[17*i +: 17] - 17'h00001;
                @(negedge clk);
                chk(erase_addr_allowed, 0);
            end
            acc(1, 16'hFFC3, 8'h00);
            acc(1, 16'hFF82, 8'h00);
            acc(0, 16'hFF82, 8'h00);
            chk({periph_area_sel, q}, 16'h0100);
            acc(1, 16'hFFC3, 8'h08);
            acc(0, 16'hFF82, 8'h00);
            chk(q, 8'h02);
        end
    endtask
    task t_clr;
        begin
            flash_enabled = 1'b0;
            acc(1, 16'hFF82, 8'h00);
            acc(0, 16'hFF82, 8'h00);
            chk(q, 8'h00);
            flash_enabled = 1'b1;
            acc(0, 16'hFF82, 8'h00);
            chk(q, 8'h02);
            software_write_enable = 1'b0;
            acc(0, 16'hFF82, 8'h00);
            software_write_enable = 1'b1;
            acc(1, 16'hFF83, 8'h10);
            standby_any = 1'b1;
            acc(0, 16'hFF82, 8'h00);
            standby_any = 1'b0;
            chk(q, 8'h00);
            acc(0, 16'hFF83, 8'h00);
            chk(q, 8'h00);
            hw_standby = 1'b1;
            acc(0, 16'hFFC3, 8'h00);
            hw_standby = 1'b0;
            chk(serial_timer_control, 8'h00);
        end
    endtask
    task t_norm;
        begin
            chk({user_mode_normal, boot_mode}, 2'b10);
            acc(1, 16'hFFC3, 8'h08);
            acc(1, 16'hFF83, 8'h80);
            acc(1, 16'hFF82, 8'h01);
            acc(0, 16'hFF83, 8'h00);
            chk(q, 8'h00);
            acc(0, 16'hFF82, 8'h00);
            chk(q, 8'h00);
            acc(1, 16'hFF83, 8'h40);
            acc(0, 16'hFF83, 8'h00);
            chk(q, 8'h40);
        end
    endtask
    task print_verdict;
        begin
            $display("errors %0d comparisons %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        err_total = err_total + 1;
        print_verdict;
    end
    initial begin
        rst(1'b0, 1'b0);
        t_boot;
        rst(1'b1, 1'b0);
        t_map;
        t_clr;
        rst(1'b0, 1'b1);
        t_norm;
        print_verdict;
    end
endmodule
